// ==== core/xpd_decode.sv ====
// decode and execute of the four extension opcodes (add, subtract, push, move) and the call via working register
`timescale 1ns/1ps
`include "xpd_map.svh"
module xpd_decode
	import xpd_pkg::*;
(
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        NRST,
	// configuration
	input  wire logic        EXT_ENABLE,
	// fetch path
	input  wire logic [15:0] INSTR,
	input  wire logic        INSTR_VALID,
	input  wire logic [20:0] PC,
	// core registers
	input  wire logic [7:0]  WORKING_REG,
	input  wire logic [7:0]  PC_HIGH_LATCH,
	input  wire logic [7:0]  PC_UPPER_LATCH,
	input  wire logic [20:0] TOP_OF_STACK,
	// data memory read
	input  wire logic [7:0]  MEM_RDATA,
	output logic      [11:0] MEM_RADDR,
	// data memory write and pc control
	output xpd_pkg::xpd_mem_t MEM_WR,
	output xpd_pkg::xpd_pc_t  PC_CTRL,
	// status
	output logic        FLUSH,
	output logic        CLAIMED,
	output logic [11:0] PTR0,
	output logic [11:0] PTR1,
	output logic [11:0] PTR2
);
	import xpd_pkg::*;

	typedef struct packed {
		xpd_state_t  state;
		logic        move_abs;
		logic [7:0]  move_data;
		xpd_mem_t    mem;
		xpd_pc_t     pc;
		logic        flush;
	} xpd_regs_t;

	xpd_regs_t   r;
	xpd_regs_t   next_r;
	logic [11:0] ptr [3];
	logic        ptr_we;
	logic [1:0]  ptr_sel;
	logic [11:0] ptr_wdata;
	logic [11:0] src_addr;
	logic [11:0] dst_addr;
	logic [3:0]  op_hi;
	logic [3:0]  op_mid;
	logic [1:0]  sel;
	logic [11:0] lit6;
	logic        ext_op;
	logic        is_addsub;
	logic        is_ret;
	logic        is_call_via_working_reg;
	logic        is_second;
	logic        src_ind;
	logic        dst_ind;

	function automatic logic is_indirect(input logic [11:0] a);
		logic win0;
		logic win1;
		logic win2;
		// indirect access registers of the three pointers, one window each
		win0        = a >= `XPD_IND_LO && a <= `XPD_IND_HI;
		win1        = (a & `XPD_IND_MASK_A) == a && a[11:3] == 9'h1FC;
		win2        = (a & `XPD_IND_MASK_B) == a && a[11:3] == 9'h1FB;
		is_indirect = win0 || win1 || win2;
	endfunction

	// pointer writes land at the taking edge, so back-to-back forms see fresh values
	xpd_ptr_file u_ptr (
		.clk   (CLK),
		.nrst  (NRST),
		.we    (ptr_we),
		.sel   (ptr_sel),
		.wdata (ptr_wdata),
		.ptr   (ptr)
	);

	assign op_hi  = INSTR[15:12];
	assign op_mid = INSTR[11:8];
	assign sel    = INSTR[7:6];
	assign lit6   = {6'h00, INSTR[5:0]};
	assign ext_op = EXT_ENABLE && INSTR_VALID && op_hi == `XPD_OP_HI_EXT &&
		(op_mid == `XPD_OP_ADD || op_mid == `XPD_OP_SUB ||
		op_mid == `XPD_OP_PUSH || op_mid == `XPD_OP_MOVE);
	assign src_addr  = ptr[2] + {5'h00, INSTR[6:0]};
	assign dst_addr  = ptr[2] + {5'h00, INSTR[6:0]};
	assign MEM_RADDR = src_addr;

	assign is_addsub = op_mid == `XPD_OP_ADD || op_mid == `XPD_OP_SUB;
	assign is_ret    = ext_op && is_addsub && sel == `XPD_SEL_RET;
	assign is_call_via_working_reg  = EXT_ENABLE && INSTR_VALID && INSTR == `XPD_OP_CALL_VIA_WORKING_REG_WORD;
	assign is_second = op_hi == `XPD_OP_HI_SECOND;
	// lookups built once here rather than in every case arm
	assign src_ind   = is_indirect(src_addr);
	assign dst_ind   = is_indirect(dst_addr);

	always_comb begin
		next_r           = r;
		next_r.mem.we    = 1'b0;
		next_r.pc        = '0;
		next_r.flush     = 1'b0;
		ptr_we           = 1'b0;
		ptr_sel          = 2'h2;
		ptr_wdata        = ptr[2];
		CLAIMED          = 1'b0;
		case (r.state)
			XPD_IDLE: begin
				if (ext_op) begin
					CLAIMED = 1'b1;
					case (op_mid)
						`XPD_OP_ADD, `XPD_OP_SUB: begin
							// no flags are touched; wrap falls out of 12-bit width
							ptr_we  = 1'b1;
							ptr_sel = (sel == `XPD_SEL_RET) ? 2'h2 : sel;
							ptr_wdata = (op_mid == `XPD_OP_ADD) ?
								ptr[ptr_sel] + lit6 :
								ptr[ptr_sel] - lit6;
							if (is_ret) begin
								next_r.pc.load   = 1'b1;
								next_r.pc.target = TOP_OF_STACK;
								next_r.pc.pop    = 1'b1;
								next_r.flush     = 1'b1;
								next_r.state     = XPD_FLUSH;
							end
						end
						`XPD_OP_PUSH: begin
							next_r.mem.we   = 1'b1;
							next_r.mem.addr = ptr[2];
							next_r.mem.data = INSTR[7:0];
							ptr_we          = 1'b1;
							ptr_wdata       = ptr[2] - 12'h001;
						end
						default: begin
							// source read now; indirect regs give zero
							next_r.move_abs  = ~INSTR[7];
							next_r.move_data = src_ind ? 8'h00 : MEM_RDATA;
							next_r.state     = XPD_MOVE2;
						end
					endcase
				end else if (is_call_via_working_reg) begin
					CLAIMED                = 1'b1;
					next_r.pc.push         = 1'b1;
					next_r.pc.push_value   = PC + `XPD_PC_STEP;
					next_r.pc.load         = 1'b1;
					next_r.pc.target       = {PC_UPPER_LATCH[4:0], PC_HIGH_LATCH,
						WORKING_REG};
					next_r.flush           = 1'b1;
					next_r.state           = XPD_FLUSH;
				end
			end
			XPD_MOVE2: begin
				// second word; only a valid 1111 word completes the move
				if (INSTR_VALID) begin
					CLAIMED = 1'b1;
					next_r.state = XPD_IDLE;
					if (is_second) begin
						next_r.mem.data = r.move_data;
						if (r.move_abs) begin
							next_r.mem.addr = INSTR[11:0];
							next_r.mem.we   = 1'b1;
						end else begin
							next_r.mem.addr = dst_addr;
							next_r.mem.we   = ~dst_ind;
						end
					end else begin
						// a stray word ends the move unwritten; the core loses that word
						next_r.mem.we = 1'b0;
					end
				end
			end
			XPD_FLUSH: begin
				// fetched word here is thrown away
				// claimed so the core cannot run it as a base opcode
				CLAIMED      = INSTR_VALID;
				next_r.state = XPD_IDLE;
			end
			default: begin
				next_r.state = XPD_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign MEM_WR  = r.mem;
	assign PC_CTRL = r.pc;
	assign FLUSH   = r.flush;
	assign PTR0    = ptr[0];
	assign PTR1    = ptr[1];
	assign PTR2    = ptr[2];
endmodule

// ==== core/xpd_map.svh ====
// offsets, field positions and fixed values of the extension decoder
`ifndef XPD_MAP_SVH
`define XPD_MAP_SVH
`define XPD_OP_HI_EXT      4'hE
`define XPD_OP_HI_SECOND   4'hF
`define XPD_OP_ADD         4'h8
`define XPD_OP_SUB         4'h9
`define XPD_OP_PUSH        4'hA
`define XPD_OP_MOVE        4'hB
`define XPD_OP_CALL_VIA_WORKING_REG_WORD  16'h0014
`define XPD_SEL_RET        2'h3
`define XPD_PC_STEP        21'h000002
`define XPD_PTR_RESET      12'h000
`define XPD_IND_LO         12'hFEB
`define XPD_IND_HI         12'hFEF
`define XPD_IND_MASK_A     12'hFE7
`define XPD_IND_MASK_B     12'hFDF
`define XPD_IND_MASK_C     12'hFD7
`endif

// ==== core/xpd_pkg.sv ====
// types of the extension decoder
package xpd_pkg;
	typedef enum logic [1:0] {
		XPD_IDLE    = 2'b00,
		XPD_FLUSH   = 2'b01,
		XPD_MOVE2   = 2'b10
	} xpd_state_t;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  data;
		logic        we;
	} xpd_mem_t;

	typedef struct packed {
		logic        load;
		logic [20:0] target;
		logic        push;
		logic [20:0] push_value;
		logic        pop;
	} xpd_pc_t;
endpackage

// ==== core/xpd_ptr_file.sv ====
// three 12-bit pointer registers with one update port
`timescale 1ns/1ps
`include "xpd_map.svh"
module xpd_ptr_file (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// update
	input  wire logic        we,
	input  wire logic [1:0]  sel,
	input  wire logic [11:0] wdata,
	// read data, registered
	output logic [11:0] ptr [3]
);
	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_ptr
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					ptr[i] <= `XPD_PTR_RESET;
				end else if (we && sel == 2'(i)) begin
					ptr[i] <= wdata;
				end
			end
		end
	endgenerate
endmodule

// ==== verif/xpd_chk.sv ====
// assertion checker for the extension decoder
`timescale 1ns/1ps
module xpd_chk
	import xpd_pkg::*;
(
	// clock and reset
	input wire logic        CLK,
	input wire logic        NRST,
	// inputs seen
	input wire logic        EXT_ENABLE,
	input wire logic [15:0] INSTR,
	input wire logic        INSTR_VALID,
	input wire logic [20:0] PC,
	input wire logic [7:0]  WORKING_REG,
	input wire logic [7:0]  PC_HIGH_LATCH,
	input wire logic [7:0]  PC_UPPER_LATCH,
	input wire logic [20:0] TOP_OF_STACK,
	// outputs seen
	input wire xpd_mem_t    MEM_WR,
	input wire xpd_pc_t     PC_CTRL,
	input wire logic        FLUSH,
	input wire logic        CLAIMED,
	input wire logic [11:0] PTR0,
	input wire logic [11:0] PTR2
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	// flushed word is never a request
	wire        ok  = INSTR_VALID && EXT_ENABLE && !FLUSH;
	wire [5:0]  k6  = INSTR[5:0];
	wire [7:0]  k8  = INSTR[7:0];
	wire [20:0] cw  = {PC_UPPER_LATCH[4:0], PC_HIGH_LATCH, WORKING_REG};
	wire        ret = ok && INSTR[15:9] == 7'h74 && INSTR[7:6] == 2'h3;
	wire        cal = ok && INSTR == 16'h0014;
	a_add_ptr_two: assert property (ok && INSTR[15:7] == 9'h1D1 |=>
		PTR2 == $past(PTR2) + $past(k6)) else $error("add to pointer two wrong");
	a_sub_ptr_zero: assert property (ok && INSTR[15:6] == 10'h3A4 |=>
		PTR0 == $past(PTR0) - $past(k6)) else $error("subtract from pointer zero wrong");
	a_ret_loads_top: assert property (ret |=> PC_CTRL.load && PC_CTRL.pop &&
		PC_CTRL.target == $past(TOP_OF_STACK)) else $error("return target wrong");
	a_ret_flush_once: assert property (ret |=> FLUSH ##1 !FLUSH)
		else $error("return flush wrong");
	a_call_push_ret: assert property (cal |=> PC_CTRL.push && FLUSH &&
		PC_CTRL.push_value == $past(PC) + 21'h000002) else $error("call push wrong");
	a_call_target: assert property (cal |=> PC_CTRL.load &&
		PC_CTRL.target == $past(cw)) else $error("call target wrong");
	a_push_store: assert property (ok && INSTR[15:8] == 8'hEA |=>
		MEM_WR == {$past(PTR2), $past(k8), 1'b1} && PTR2 == $past(PTR2) - 12'h001)
		else $error("push literal wrong");
	a_off_no_claim: assert property (INSTR_VALID && !EXT_ENABLE |-> !CLAIMED)
		else $error("claimed while disabled");
	c_ret: cover property (ret);
	c_call: cover property (cal);
	c_push: cover property (MEM_WR.we);
endmodule
bind xpd_decode xpd_chk xpd_chk_i (.CLK, .NRST, .EXT_ENABLE, .INSTR, .INSTR_VALID, .PC,
	.WORKING_REG, .PC_HIGH_LATCH, .PC_UPPER_LATCH, .TOP_OF_STACK, .MEM_WR, .PC_CTRL, .FLUSH,
	.CLAIMED, .PTR0, .PTR2);

// ==== verif/xpd_core_model.sv ====
// data memory and return stack beside the extension decoder
`timescale 1ns/1ps
module xpd_core_model
	import xpd_pkg::*;
(
	// clock
	input  wire logic        clk,
	// decoder side
	input  wire logic [11:0] raddr,
	input  wire xpd_mem_t    wr,
	input  wire xpd_pc_t     pcc,
	// answers
	output logic      [7:0]  rdata,
	output logic      [20:0] top
);
	logic [7:0]  mem [4096];
	logic [20:0] stk [8];
	logic [2:0]  sp = 3'h0;
	assign rdata = mem[raddr];
	assign top = stk[sp];
	// known pattern so moved bytes can be predicted
	initial begin
		for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'hA5;
		for (int i = 0; i < 8; i++) stk[i] = 21'h001234 + 21'(i);
	end
	always @(posedge clk) begin
		if (wr.we) mem[wr.addr] <= wr.data;
		if (pcc.push) begin
			stk[sp + 3'h1] <= pcc.push_value;
			sp <= sp + 3'h1;
		end else if (pcc.pop) sp <= sp - 3'h1;
	end
endmodule

// ==== verif/xpd_decode_tb_top.sv ====
// testbench for the extension decoder
`timescale 1ns/1ps
module xpd_decode_tb_top;
	import xpd_pkg::*;
	logic        CLK = 1'b0;
	logic        NRST = 1'b0;
	logic        EXT_ENABLE = 1'b1;
	logic        INSTR_VALID = 1'b0;
	logic [15:0] INSTR = 16'h0000;
	logic [20:0] PC = 21'h000100;
	logic [7:0]  WORKING_REG = 8'h06;
	logic [7:0]  PC_HIGH_LATCH = 8'h10;
	logic [7:0]  PC_UPPER_LATCH = 8'h00;
	logic [7:0]  MEM_RDATA;
	logic [20:0] TOP_OF_STACK;
	logic [11:0] MEM_RADDR, PTR0, PTR1, PTR2;
	xpd_mem_t    MEM_WR;
	xpd_pc_t     PC_CTRL;
	logic        FLUSH, CLAIMED;
	int          fail_count = 0;
	int          cmp_count = 0;
	xpd_decode xpd_decode_i (.CLK, .NRST, .EXT_ENABLE, .INSTR, .INSTR_VALID, .PC, .WORKING_REG,
		.PC_HIGH_LATCH, .PC_UPPER_LATCH, .TOP_OF_STACK, .MEM_RDATA, .MEM_RADDR, .MEM_WR,
		.PC_CTRL, .FLUSH, .CLAIMED, .PTR0, .PTR1, .PTR2);
	xpd_core_model xpd_core_model_i (.clk(CLK), .raddr(MEM_RADDR), .wr(MEM_WR), .pcc(PC_CTRL),
		.rdata(MEM_RDATA), .top(TOP_OF_STACK));
	initial forever #20 CLK = ~CLK;
	task automatic chk(input string n, input logic [20:0] e, input logic [20:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic op(input logic [15:0] w);
		@(posedge CLK);
		INSTR <= w;
		INSTR_VALID <= 1'b1;
	endtask
	// next word goes in, earlier answer settles
	task automatic step(input logic [15:0] w);
		@(posedge CLK);
		INSTR <= w;
		#1;
	endtask
	task automatic fin(input string n);
		@(posedge CLK);
		INSTR_VALID <= 1'b0;
		#1 $display("test %s done", n);
	endtask
	task automatic t_ptr;
		op(16'hE8BF);
		op(16'hE87F);
		op(16'hE93F);
		fin("ptr");
		chk("ptr2", 12'h03F, PTR2);
		chk("ptr1", 12'h03F, PTR1);
		chk("ptr0", 12'hFC1, PTR0);
	endtask
	task automatic t_ret;
		op(16'hE9C1);
		step(16'hE8BF);
		chk("target", 21'h001234, PC_CTRL.target);
		chk("flush", 1'b1, FLUSH);
		fin("ret");
		chk("ptr2", 12'h03E, PTR2);
	endtask
	task automatic t_call;
		op(16'h0014);
		step(16'hE8BF);
		chk("push", 21'h000102, PC_CTRL.push_value);
		chk("target", 21'h001006, PC_CTRL.target);
		fin("call");
		chk("ptr2", 12'h03E, PTR2);
	endtask
	task automatic t_push;
		op(16'hEA5A);
		step(16'hEAC3);
		chk("wr", {12'h03E, 8'h5A, 1'b1}, MEM_WR);
		fin("push");
		chk("wr", {12'h03D, 8'hC3, 1'b1}, MEM_WR);
		chk("ptr2", 12'h03C, PTR2);
	endtask
	task automatic t_move;
		op(16'hEB05);
		#1 chk("raddr", 12'h041, MEM_RADDR);
		op(16'hF123);
		fin("abs");
		chk("wr", {12'h123, 8'hE4, 1'b1}, MEM_WR);
		op(16'hEB85);
		op(16'hF006);
		fin("idx");
		chk("wr", {12'h042, 8'hE4, 1'b1}, MEM_WR);
	endtask
	task automatic t_off;
		op(16'hEA11);
		EXT_ENABLE <= 1'b0;
		#1 chk("claimed", 1'b0, CLAIMED);
		fin("off");
		chk("we", 1'b0, MEM_WR.we);
		chk("ptr2", 12'h03C, PTR2);
		@(posedge CLK);
		EXT_ENABLE <= 1'b1;
	endtask
	task automatic t_ind;
		op(16'hE9BC);
		op(16'hE994);
		op(16'hEB80);
		op(16'hF010);
		fin("ind_src");
		chk("wr", {12'hFFC, 8'h00, 1'b1}, MEM_WR);
		chk("ptr2", 12'hFEC, PTR2);
		op(16'hEB91);
		op(16'hF000);
		fin("ind_dst");
		chk("we", 1'b0, MEM_WR.we);
		op(16'hE8C4);
		step(16'hEA77);
		chk("load", 1'b1, PC_CTRL.load);
		chk("pop", 1'b1, PC_CTRL.pop);
		chk("target", 21'h000102, PC_CTRL.target);
		fin("add_ret");
		chk("we", 1'b0, MEM_WR.we);
		chk("ptr2", 12'hFF0, PTR2);
		op(16'hEB85);
		op(16'hE801);
		fin("drop");
		chk("we", 1'b0, MEM_WR.we);
		chk("ptr0", 12'hFC1, PTR0);
	endtask
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge CLK);
		NRST <= 1'b1;
		t_ptr();
		t_ret();
		t_call();
		t_push();
		t_move();
		t_off();
		t_ind();
		give_verdict();
	end
	// a few dozen cycles are needed; the run ends far sooner than this
	initial begin
		repeat (500) @(posedge CLK);
		fail_count++;
		give_verdict();
	end
endmodule
